// ### verilog/nibble_io_pkg.sv
// shared constants, types and helpers for the three nibble i/o ports
package nibble_io_pkg;

  // widths of the processor side busses and of the comparator channel field
  localparam int ADDR_W = 7;
  localparam int NIB_W = 4;
  localparam int CH_W = 2;

  typedef logic [ADDR_W-1:0] addr_t;
  typedef logic [NIB_W-1:0] nib_t;
  typedef logic [CH_W-1:0] chan_t;

  // bank-0 data memory locations of the port registers
  localparam addr_t DM_FIRST_PORT = 7'h70;
  localparam addr_t DM_SECOND_PORT = 7'h71;
  localparam addr_t DM_THIRD_PORT = 7'h72;

  // register file locations of the port configuration
  localparam addr_t RF_CMP_CHANNEL = 7'h1C;
  localparam addr_t RF_THIRD_ANALOG = 7'h23;
  localparam addr_t RF_SECOND_GROUP = 7'h24;
  localparam addr_t RF_THIRD_DIR = 7'h34;
  localparam addr_t RF_FIRST_DIR = 7'h35;

  // field positions and reset values
  localparam int GROUP_DIR_BIT = 0;
  localparam nib_t NIB_RESET = 4'h0;
  localparam chan_t CHAN_RESET = 2'h0;
  localparam logic BIT_RESET = 1'b0;

  // per bit: outputs read back the latch, inputs read the pin
  function automatic nib_t port_read_view(nib_t dir, nib_t pin,
                                          nib_t latch);
    return (dir & latch) | (~dir & pin);
  endfunction : port_read_view

  // one group direction bit steers all four pins
  function automatic nib_t fan_group(logic grp);
    return {NIB_W{grp}};
  endfunction : fan_group

endpackage : nibble_io_pkg

// ### verilog/port_cfg_if.sv
// configuration bundle from the register file to the port logic
`timescale 1ns/1ps
interface port_cfg_if;
  import nibble_io_pkg::*;
  nib_t dir_first;   // per pin direction, first port
  logic dir_group;   // group direction, second port
  nib_t dir_third;   // per pin direction, third port
  nib_t analog_sel;  // third port pins routed to comparator
  chan_t cmp_chan;   // comparator channel select
  modport cfg (output dir_first, dir_group, dir_third, analog_sel,
               cmp_chan);
  modport user (input dir_first, dir_group, dir_third, analog_sel,
                cmp_chan);
endinterface : port_cfg_if

// ### verilog/port_nibble_latch.sv
// one 4-bit port output latch and its read view
`timescale 1ns/1ps
module port_nibble_latch
  import nibble_io_pkg::*;
(
  // clock, reset, enable
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic ce,
  // processor write strobe and data
  input wire logic wr,
  input wire nib_t wdata,
  // pin side
  input wire nib_t dir,
  input wire nib_t pin_in,
  output nib_t latch,
  output nib_t rview
);

  typedef struct packed {
    nib_t latch; // output latch contents
  } state_t;

  state_t st;
  state_t next_st;

  // latch takes every write whatever the direction
  always_comb begin
    next_st = st;
    if (ce && wr) begin
      next_st.latch = wdata;
    end
  end

  // cleared at reset, so pins start driving zero if turned to output
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      st <= '{latch: NIB_RESET};
    end else begin
      st <= next_st;
    end
  end

  assign latch = st.latch;
  assign rview = port_read_view(dir, pin_in, st.latch);

endmodule : port_nibble_latch

// ### verilog/port_cfg_regs.sv
// register file locations that configure the three ports
`timescale 1ns/1ps
module port_cfg_regs
  import nibble_io_pkg::*;
#(
  parameter bit HAS_CMP = 1'b1
)
(
  // clock, reset, enable
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic ce,
  // register file write and read view
  input wire logic rf_wr,
  input wire addr_t rf_addr,
  input wire nib_t rf_wdata,
  output nib_t rf_rview,
  // configuration out
  port_cfg_if.cfg cfg
);

  typedef struct packed {
    nib_t dir_first;
    logic dir_group;
    nib_t dir_third;
    nib_t analog_sel;
    chan_t cmp_chan;
  } state_t;

  state_t st;
  state_t next_st;

  // decode writes; comparator fields take writes only in that variant
  always_comb begin
    next_st = st;
    if (ce && rf_wr) begin
      unique case (rf_addr)
        RF_FIRST_DIR: next_st.dir_first = rf_wdata;
        RF_SECOND_GROUP: next_st.dir_group = rf_wdata[GROUP_DIR_BIT];
        RF_THIRD_DIR: next_st.dir_third = rf_wdata;
        RF_THIRD_ANALOG: if (HAS_CMP) next_st.analog_sel = rf_wdata;
        RF_CMP_CHANNEL: if (HAS_CMP) next_st.cmp_chan = rf_wdata[CH_W-1:0];
        default: ;
      endcase
    end
  end

  // read view, unused bits and unknown locations give zero
  always_comb begin
    rf_rview = NIB_RESET;
    unique case (rf_addr)
      RF_FIRST_DIR: rf_rview = st.dir_first;
      RF_SECOND_GROUP: rf_rview[GROUP_DIR_BIT] = st.dir_group;
      RF_THIRD_DIR: rf_rview = st.dir_third;
      RF_THIRD_ANALOG: rf_rview = st.analog_sel;
      RF_CMP_CHANNEL: rf_rview = NIB_W'(st.cmp_chan);
      default: ;
    endcase
  end

  // every pin comes out of reset as an input, port function
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      st <= '{NIB_RESET, BIT_RESET, NIB_RESET, NIB_RESET, CHAN_RESET};
    end else begin
      st <= next_st;
    end
  end

  assign cfg.dir_first = st.dir_first;
  assign cfg.dir_group = st.dir_group;
  assign cfg.dir_third = st.dir_third;
  assign cfg.analog_sel = st.analog_sel;
  assign cfg.cmp_chan = st.cmp_chan;

endmodule : port_cfg_regs

// ### verilog/nibble_io_ports_abc.sv
// three 4-bit general purpose i/o ports with output latches
//
// Behaviour
// - first port register at data memory 70H
// - first port direction per pin at 35H
// - first port input pin reads pin level
// - first port output pin drives, reads latch
// - reset: first port inputs, latch zero
// - second port register at data memory 71H
// - second port group direction, 24H bit 0
// - group bit 0: inputs, reads pins
// - group bit 1: outputs, reads latch
// - reset: second port inputs, latch zero
// - third port at 72H, directions at 34H
// - reset: third port inputs, latch zero
// - analog select per third pin at 23H
// - comparator channel field at 1CH
// - third port writes always reach latch
// - analog plus output still drives latch
// - reset clears analog select and directions
`timescale 1ns/1ps
module nibble_io_ports_abc
  import nibble_io_pkg::*;
#(
  parameter bit HAS_CMP = 1'b1 // comparator-equipped variant
)
(
  // clock, reset, enable
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic ce,
  // bank-0 data memory access
  input wire addr_t dm_addr,
  input wire logic dm_wr,
  input wire logic dm_rd,
  input wire nib_t dm_wdata,
  output nib_t dm_rdata,
  // register file access
  input wire addr_t rf_addr,
  input wire logic rf_wr,
  input wire logic rf_rd,
  input wire nib_t rf_wdata,
  output nib_t rf_rdata,
  // first port pins
  input wire nib_t first_port_in,
  output nib_t first_port_out,
  output nib_t first_port_oe,
  // second port pins
  input wire nib_t second_port_in,
  output nib_t second_port_out,
  output nib_t second_port_oe,
  // third port pins
  input wire nib_t third_port_in,
  output nib_t third_port_out,
  output nib_t third_port_oe,
  // comparator controls
  output nib_t third_port_analog_sel,
  output chan_t cmp_channel_sel
);

  // top level state: the two registered read busses
  typedef struct packed {
    nib_t dm_rdata; // last data memory read result
    nib_t rf_rdata; // last register file read result
  } state_t;

  state_t st;      // registered state
  state_t next_st; // its next value

  port_cfg_if cfg_bus (); // configuration bundle

  // per port write strobes out of the data memory decode
  logic wr_first;
  logic wr_second;
  logic wr_third;

  // read views: pin or latch per direction
  nib_t view_first;
  nib_t view_second;
  nib_t view_third;
  nib_t rf_view;

  // latch contents, driven onto pins when output
  nib_t latch_first;
  nib_t latch_second;
  nib_t latch_third;

  // group direction fanned out to the four second port pins
  nib_t dir_second;

  // data memory write decode, one location per port
  always_comb begin
    wr_first = dm_wr && (dm_addr == DM_FIRST_PORT);
    wr_second = dm_wr && (dm_addr == DM_SECOND_PORT);
    wr_third = dm_wr && (dm_addr == DM_THIRD_PORT);
  end

  // a single bit sets all four pins of the second port
  assign dir_second = fan_group(cfg_bus.dir_group);

  // configuration registers in the register file
  port_cfg_regs #(
    .HAS_CMP(HAS_CMP)
  ) u_cfg (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .ce(ce),
    .rf_wr(rf_wr),
    .rf_addr(rf_addr),
    .rf_wdata(rf_wdata),
    .rf_rview(rf_view),
    .cfg(cfg_bus)
  );

  // first port: per pin direction
  port_nibble_latch u_first (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .ce(ce),
    .wr(wr_first),
    .wdata(dm_wdata),
    .dir(cfg_bus.dir_first),
    .pin_in(first_port_in),
    .latch(latch_first),
    .rview(view_first)
  );

  // second port: group direction
  port_nibble_latch u_second (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .ce(ce),
    .wr(wr_second),
    .wdata(dm_wdata),
    .dir(dir_second),
    .pin_in(second_port_in),
    .latch(latch_second),
    .rview(view_second)
  );

  // third port: analog select never blocks the latch or the drive
  port_nibble_latch u_third (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .ce(ce),
    .wr(wr_third),
    .wdata(dm_wdata),
    .dir(cfg_bus.dir_third),
    .pin_in(third_port_in),
    .latch(latch_third),
    .rview(view_third)
  );

  // read capture; unknown locations answer zero
  always_comb begin
    next_st = st;
    if (ce && dm_rd) begin
      unique case (dm_addr)
        DM_FIRST_PORT: next_st.dm_rdata = view_first;
        DM_SECOND_PORT: next_st.dm_rdata = view_second;
        DM_THIRD_PORT: next_st.dm_rdata = view_third;
        default: next_st.dm_rdata = NIB_RESET;
      endcase
    end
    if (ce && rf_rd) begin
      next_st.rf_rdata = rf_view;
    end
  end

  // read busses hold their value until the next read
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      st <= '{NIB_RESET, NIB_RESET};
    end else begin
      st <= next_st;
    end
  end

  // read results, straight from the state flops
  assign dm_rdata = st.dm_rdata;
  assign rf_rdata = st.rf_rdata;

  // pins drive the latch whenever direction is output
  assign first_port_out = latch_first;
  assign first_port_oe = cfg_bus.dir_first;
  assign second_port_out = latch_second;
  assign second_port_oe = dir_second;
  assign third_port_out = latch_third;
  // analog pins still drive when output; software must avoid it
  assign third_port_oe = cfg_bus.dir_third;

  // comparator routing and channel select
  assign third_port_analog_sel = cfg_bus.analog_sel;
  assign cmp_channel_sel = cfg_bus.cmp_chan;

  // checks, all in the single clock domain
  default clocking chk_clk @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);

  // a write to the first port lands in its latch
  first_latch_a: assert property (
    ce && dm_wr && dm_addr == DM_FIRST_PORT
    |=> first_port_out == $past(dm_wdata))
    else $error("first port latch missed a write");

  // a direction write steers the first port enables
  first_dir_a: assert property (
    ce && rf_wr && rf_addr == RF_FIRST_DIR
    |=> first_port_oe == $past(rf_wdata))
    else $error("first port direction not taken");

  // inputs read the pin level
  first_in_read_a: assert property (
    ce && dm_rd && dm_addr == DM_FIRST_PORT
    && first_port_oe == NIB_RESET
    |=> dm_rdata == $past(first_port_in))
    else $error("first port input read not pin");

  // outputs read the latch, whatever the pin shows
  first_out_read_a: assert property (
    ce && dm_rd && dm_addr == DM_FIRST_PORT
    && first_port_oe == fan_group(1'b1)
    |=> dm_rdata == $past(first_port_out))
    else $error("first port output read not latch");

  // right after reset the first and second ports are inputs with cleared latches
  reset_state_a: assert property (
    $rose(rst_b) |-> first_port_oe == NIB_RESET
    && first_port_out == NIB_RESET && second_port_oe == NIB_RESET
    && second_port_out == NIB_RESET)
    else $error("first or second port not reset");

  // group bit enables or releases all four second port pins
  group_dir_a: assert property (
    ce && rf_wr && rf_addr == RF_SECOND_GROUP
    |=> second_port_oe == fan_group($past(rf_wdata[GROUP_DIR_BIT])))
    else $error("group direction not fanned out");

  // group input mode reads pins
  second_in_read_a: assert property (
    ce && dm_rd && dm_addr == DM_SECOND_PORT
    && second_port_oe == NIB_RESET
    |=> dm_rdata == $past(second_port_in))
    else $error("second port input read not pin");

  // group output mode reads latch
  second_out_read_a: assert property (
    ce && dm_rd && dm_addr == DM_SECOND_PORT
    && second_port_oe != NIB_RESET
    |=> dm_rdata == $past(second_port_out))
    else $error("second port output read not latch");

  // third port reset state, analog select included
  third_reset_a: assert property (
    $rose(rst_b) |-> third_port_oe == NIB_RESET
    && third_port_out == NIB_RESET
    && third_port_analog_sel == NIB_RESET)
    else $error("third port not reset");

  // third port writes land in the latch in any mode
  third_latch_a: assert property (
    ce && dm_wr && dm_addr == DM_THIRD_PORT
    |=> third_port_out == $past(dm_wdata))
    else $error("third port latch missed a write");

  // analog and output: still reads the latch
  analog_out_read_a: assert property (
    ce && dm_rd && dm_addr == DM_THIRD_PORT
    && third_port_oe == fan_group(1'b1)
    && third_port_analog_sel == fan_group(1'b1)
    |=> dm_rdata == $past(third_port_out))
    else $error("analog output pin read not latch");

  // analog select write reaches the comparator routing
  analog_sel_a: assert property (
    ce && rf_wr && rf_addr == RF_THIRD_ANALOG && HAS_CMP
    |=> third_port_analog_sel == $past(rf_wdata))
    else $error("analog select not taken");

  // channel field write reaches the comparator
  cmp_channel_a: assert property (
    ce && rf_wr && rf_addr == RF_CMP_CHANNEL && HAS_CMP
    |=> cmp_channel_sel == $past(rf_wdata[CH_W-1:0]))
    else $error("comparator channel not taken");

  // a latch written as input shows once turned to output
  late_drive_a: assert property (
    ce && dm_wr && dm_addr == DM_FIRST_PORT
    && first_port_oe == NIB_RESET
    ##1 ce && rf_wr && rf_addr == RF_FIRST_DIR && !dm_wr
    |=> first_port_out == $past(dm_wdata, 2))
    else $error("input mode write lost");

  // freeze: no enable, no change of the read bus
  freeze_a: assert property (
    !ce |=> $stable(dm_rdata) && $stable(rf_rdata))
    else $error("state moved with clock enable low");

  // no first port write, no change of its latch
  latch_hold_a: assert property (
    !(ce && dm_wr && dm_addr == DM_FIRST_PORT)
    |=> $stable(first_port_out))
    else $error("first port latch moved without a write");

  // a write to the second port lands in its latch
  second_latch_a: assert property (
    ce && dm_wr && dm_addr == DM_SECOND_PORT
    |=> second_port_out == $past(dm_wdata))
    else $error("second port latch missed a write");

  // third port direction write steers its enables
  third_dir_a: assert property (
    ce && rf_wr && rf_addr == RF_THIRD_DIR
    |=> third_port_oe == $past(rf_wdata))
    else $error("third port direction not taken");

  // third port inputs read the pin, analog or not
  third_in_read_a: assert property (
    ce && dm_rd && dm_addr == DM_THIRD_PORT
    && third_port_oe == NIB_RESET
    |=> dm_rdata == $past(third_port_in))
    else $error("third port input read not pin");

  // third port outputs read the latch
  third_out_read_a: assert property (
    ce && dm_rd && dm_addr == DM_THIRD_PORT
    && third_port_oe == fan_group(1'b1)
    |=> dm_rdata == $past(third_port_out))
    else $error("third port output read not latch");

  // direction register reads back what drives the enables
  dir_readback_a: assert property (
    ce && rf_rd && rf_addr == RF_FIRST_DIR
    |=> rf_rdata == $past(first_port_oe))
    else $error("first port direction read back wrong");

  // freeze: latches and enables hold with clock enable low
  freeze_pins_a: assert property (
    !ce |=> $stable(first_port_out) && $stable(second_port_out)
    && $stable(third_port_out) && $stable(first_port_oe)
    && $stable(second_port_oe) && $stable(third_port_oe))
    else $error("pins moved with clock enable low");

  // main scenarios
  first_out_c: cover property (
    first_port_oe != NIB_RESET ##1 dm_rd && dm_addr == DM_FIRST_PORT);
  group_out_c: cover property (
    $rose(second_port_oe[0]) ##1 dm_wr && dm_addr == DM_SECOND_PORT);
  analog_in_c: cover property (
    third_port_analog_sel != NIB_RESET && third_port_oe == NIB_RESET
    && dm_rd && dm_addr == DM_THIRD_PORT);
  analog_out_c: cover property (
    (third_port_analog_sel & third_port_oe) != NIB_RESET);

endmodule : nibble_io_ports_abc

// ### verification/port_pin_model.sv
// outside world on one 4-bit port: drivers and loads on the pins
`timescale 1ns/1ps
module port_pin_model
  import nibble_io_pkg::*;
(
  // outside drive requested by the bench
  input wire nib_t ext_val,
  input wire logic fight,
  // device side of the port
  input wire nib_t pin_out,
  input wire nib_t pin_oe,
  output nib_t pin_lvl
);
  // released pins follow the outside driver; a driven pin shows the latch
  // unless the bench orders a stronger outside driver to overpower it
  assign pin_lvl = fight ? ext_val : (pin_oe & pin_out) | (~pin_oe & ext_val);
endmodule : port_pin_model

// ### verification/tb_nibble_io_ports_abc.sv
// self-checking bench for the three nibble i/o ports
`timescale 1ns/1ps
module tb_nibble_io_ports_abc;
  import nibble_io_pkg::*;
  // clock, reset and bus drive
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic ce = 1'b1;
  addr_t dm_addr = 7'h00;
  addr_t rf_addr = 7'h00;
  logic dm_wr = 1'b0;
  logic dm_rd = 1'b0;
  logic rf_wr = 1'b0;
  logic rf_rd = 1'b0;
  nib_t dm_wdata = 4'h0;
  nib_t rf_wdata = 4'h0;
  nib_t dm_rdata, rf_rdata, pa, pb, pc, oa, ob, oc, ea, eb, ec, an_o;
  chan_t ch_o;
  nib_t ext [3] = '{4'h0, 4'h0, 4'h0};
  logic fight = 1'b0;
  // shadow of the documented state
  nib_t la, lb, lc, da, dc, an;
  logic grp;
  chan_t ch;
  int error_cnt = 0;
  int total_checks = 0;
  int cycles = 0;
  int seed = 81766;
  addr_t regs [8] = '{RF_FIRST_DIR, RF_SECOND_GROUP, RF_THIRD_DIR,
    RF_THIRD_ANALOG, RF_CMP_CHANNEL, DM_FIRST_PORT, DM_SECOND_PORT,
    DM_THIRD_PORT};
  nib_t qa, qb, qc;

  always #12.5 sys_clk = ~sys_clk;

  nibble_io_ports_abc nibble_io_ports_abc_inst (.sys_clk(sys_clk),
    .rst_b(rst_b), .ce(ce), .dm_addr(dm_addr), .dm_wr(dm_wr),
    .dm_rd(dm_rd), .dm_wdata(dm_wdata), .dm_rdata(dm_rdata),
    .rf_addr(rf_addr), .rf_wr(rf_wr), .rf_rd(rf_rd), .rf_wdata(rf_wdata),
    .rf_rdata(rf_rdata), .first_port_in(pa), .first_port_out(qa),
    .first_port_oe(oa), .second_port_in(pb), .second_port_out(qb),
    .second_port_oe(ob), .third_port_in(pc), .third_port_out(qc),
    .third_port_oe(oc), .third_port_analog_sel(an_o),
    .cmp_channel_sel(ch_o));
  port_pin_model port_a_inst (.ext_val(ext[0]), .fight(fight),
    .pin_out(qa), .pin_oe(oa), .pin_lvl(pa));
  port_pin_model port_b_inst (.ext_val(ext[1]), .fight(fight),
    .pin_out(qb), .pin_oe(ob), .pin_lvl(pb));
  port_pin_model port_c_inst (.ext_val(ext[2]), .fight(fight),
    .pin_out(qc), .pin_oe(oc), .pin_lvl(pc));

  // expected read view: outputs give the latch, inputs the pin level
  function automatic nib_t view(nib_t dir, nib_t latch, nib_t e);
    nib_t lvl;
    lvl = fight ? e : (dir & latch) | (~dir & e);
    return (dir & latch) | (~dir & lvl);
  endfunction : view

  // expected value of a read at any address
  function automatic nib_t expect_rd(addr_t a);
    case (a)
      RF_FIRST_DIR: return da;
      RF_SECOND_GROUP: return {3'h0, grp};
      RF_THIRD_DIR: return dc;
      RF_THIRD_ANALOG: return an;
      RF_CMP_CHANNEL: return {2'h0, ch};
      DM_FIRST_PORT: return view(da, la, ext[0]);
      DM_SECOND_PORT: return view({4{grp}}, lb, ext[1]);
      DM_THIRD_PORT: return view(dc, lc, ext[2]);
      default: return 4'h0;
    endcase
  endfunction : expect_rd

  task automatic check(input nib_t got, input nib_t exp);
    total_checks++;
    if (got !== exp) begin
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      error_cnt++;
    end
  endtask : check

  // one strobe on either bus; the answer has settled when the task ends
  task automatic access(input logic wr, input addr_t a, input nib_t d);
    @(negedge sys_clk);
    if (a < DM_FIRST_PORT) begin
      rf_addr = a;
      rf_wdata = d;
      rf_wr = wr;
      rf_rd = !wr;
    end else begin
      dm_addr = a;
      dm_wdata = d;
      dm_wr = wr;
      dm_rd = !wr;
    end
    @(negedge sys_clk);
    {rf_wr, rf_rd, dm_wr, dm_rd} = 4'h0;
    @(negedge sys_clk);
    if (!wr || !ce) return;
    case (a)
      RF_FIRST_DIR: da = d;
      RF_SECOND_GROUP: grp = d[GROUP_DIR_BIT];
      RF_THIRD_DIR: dc = d;
      RF_THIRD_ANALOG: an = d;
      RF_CMP_CHANNEL: ch = d[1:0];
      DM_FIRST_PORT: la = d;
      DM_SECOND_PORT: lb = d;
      DM_THIRD_PORT: lc = d;
      default: ;
    endcase
  endtask : access

  task automatic rd(input addr_t a);
    access(1'b0, a, 4'h0);
    check((a < DM_FIRST_PORT) ? rf_rdata : dm_rdata, expect_rd(a));
  endtask : rd

  // pins, enables and every register, plus two unmapped places
  task automatic check_all();
    check(qa, la);
    check(qb, lb);
    check(qc, lc);
    check(oa, da);
    check(ob, {4{grp}});
    check(oc, dc);
    check(an_o, an);
    check({2'h0, ch_o}, {2'h0, ch});
    for (int i = 0; i < 8; i++) begin
      rd(regs[i]);
    end
    rd(7'h10);
    rd(7'h73);
  endtask : check_all

  // reset held 20 cycles; the shadow returns to its documented state
  task automatic reset_dut();
    @(negedge sys_clk);
    rst_b = 1'b0;
    repeat (20) @(negedge sys_clk);
    {la, lb, lc, da, dc, an} = '0;
    grp = 1'b0;
    ch = 2'h0;
    rst_b = 1'b1;
  endtask : reset_dut

  task automatic finish_test();
    $display("checks=%0d errors=%0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : finish_test

  // hang guard, far above the few thousand cycles the run needs
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      finish_test();
    end
  end

  initial begin
    logic [31:0] r;
    reset_dut();
    ext = '{4'h9, 4'h6, 4'hC};
    check_all();
    // latch written while an input, shown once the pin turns output
    access(1'b1, DM_FIRST_PORT, 4'h5);
    rd(DM_FIRST_PORT);
    access(1'b1, RF_FIRST_DIR, 4'hF);
    check_all();
    // analog pins set at start-up and kept as inputs
    access(1'b1, RF_THIRD_ANALOG, 4'hF);
    access(1'b1, DM_THIRD_PORT, 4'hA);
    check_all();
    // analog plus output, with the pins fought from outside
    fight = 1'b1;
    access(1'b1, RF_THIRD_DIR, 4'hF);
    access(1'b1, RF_SECOND_GROUP, 4'hF);
    access(1'b1, RF_CMP_CHANNEL, 4'hF);
    check_all();
    // frozen clock enable: the write is ignored
    ce = 1'b0;
    access(1'b1, DM_SECOND_PORT, 4'h3);
    ce = 1'b1;
    check(qb, lb);
    // back to back: latch written as input, direction flipped next cycle
    access(1'b1, RF_FIRST_DIR, 4'h0);
    @(negedge sys_clk);
    dm_addr = DM_FIRST_PORT;
    dm_wdata = 4'h6;
    dm_wr = 1'b1;
    @(negedge sys_clk);
    dm_wr = 1'b0;
    rf_addr = RF_FIRST_DIR;
    rf_wdata = 4'hF;
    rf_wr = 1'b1;
    @(negedge sys_clk);
    rf_wr = 1'b0;
    la = 4'h6;
    da = 4'hF;
    check(qa, la);
    check(oa, da);
    // random traffic with random pin levels
    for (int n = 0; n < 60; n++) begin
      r = $random(seed);
      fight = r[20];
      ext = '{r[11:8], r[15:12], r[19:16]};
      access(1'b1, regs[r[2:0]], r[7:4]);
      if (r[3]) begin
        access(1'b1, 7'h11, r[7:4]);
      end
      check_all();
    end
    // second reset in mid-run
    reset_dut();
    check_all();
    finish_test();
  end
endmodule : tb_nibble_io_ports_abc
